// ==== gpp_port.sv ====
// Purpose: Six-bit bidirectional port with change detect and pull-ups.
// Assumes: One 10 MHz clock; config straps are static, same domain.
// Notes: nrst is power-on reset; soft_rst covers master clear and
//    brown-out and spares the last-read capture.
`timescale 1ns/100ps
module gpp_port (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic soft_rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic mem_move_access,
   output logic [7:0] reg_rdata,
   input wire logic master_clear_enable_cfg,
   input wire logic osc_claims_pins,
   input wire logic osc_crystal_mode,
   input wire logic [5:0] pin_in,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe,
   output logic [5:0] pullup_on,
   output logic [3:0] analog_sel,
   output logic change_irq,
   output logic wake_req
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [5:0] dir;
      logic [5:0] lat;
      logic [5:0] wpu;
      logic [5:0] chg_en;
      logic [3:0] analog_select_bits;
      logic gie;
      logic flag;
      logic pudis;
      logic [5:0] last;
      logic [5:0] s1;
      logic [5:0] s2;
      logic [5:0] s3;
      logic [5:0] pinq;
      logic [7:0] rdata;
      logic [5:0] pout;
      logic [5:0] poe;
      logic [5:0] pu;
      logic irq;
   } gpp_state_t;

   localparam gpp_state_t ST_RST = '{
      dir: gpp_pkg::DIR_RST, lat: gpp_pkg::LATCH_RST,
      wpu: gpp_pkg::PULLUP_RST, chg_en: gpp_pkg::CHG_EN_RST,
      analog_select_bits: gpp_pkg::ANALOG_RST, gie: gpp_pkg::GIE_RST, flag: 1'b0,
      pudis: gpp_pkg::PUDIS_RST, last: gpp_pkg::LAST_RST,
      s1: 6'h00, s2: 6'h00, s3: 6'h00, pinq: 6'h00, rdata: 8'h00,
      pout: 6'h00, poe: 6'h00, pu: 6'h00, irq: 1'b0};

   gpp_state_t st_r;
   gpp_state_t st_nxt;

   logic [5:0] avail_w;
   logic [5:0] dir_in_w;
   logic [5:0] mismatch_w;
   logic any_mismatch_w;
   logic level_access_w;
   logic [5:0] level_rd_w;
   logic [5:0] dir_rd_w;
   logic [5:0] lat_rd_w;
   logic [7:0] rd_mux_w;

   // ----------------------------------------------------------------
   // Pin configuration and read views
   // ----------------------------------------------------------------
   always_comb begin
      // Pins that behave as port pins under the current straps
      avail_w = gpp_pkg::ALL_PIN_MASK;
      if (master_clear_enable_cfg) begin
         avail_w = avail_w & ~gpp_pkg::PIN_THREE_MASK;
      end
      if (osc_claims_pins) begin
         avail_w = avail_w & ~gpp_pkg::OSC_PIN_MASK;
      end
      // Pin three and claimed pins never drive
      dir_in_w = st_r.dir | gpp_pkg::PIN_THREE_MASK;
      if (osc_claims_pins) begin
         dir_in_w = dir_in_w | gpp_pkg::OSC_PIN_MASK;
      end
      // Outputs drop out of the comparison
      mismatch_w = (st_r.pinq ^ st_r.last) & st_r.chg_en
         & dir_in_w & avail_w;
      any_mismatch_w = |mismatch_w;
      level_access_w = (reg_rd | reg_wr) && !mem_move_access
         && reg_addr == gpp_pkg::ADDR_LEVEL;
      level_rd_w = st_r.pinq & avail_w;
      dir_rd_w = st_r.dir | gpp_pkg::PIN_THREE_MASK;
      lat_rd_w = st_r.lat & ~gpp_pkg::PIN_THREE_MASK;
      if (osc_claims_pins) begin
         dir_rd_w = dir_rd_w & ~gpp_pkg::OSC_PIN_MASK;
         lat_rd_w = lat_rd_w & ~gpp_pkg::OSC_PIN_MASK;
      end
      if (osc_crystal_mode) begin
         dir_rd_w = dir_rd_w | gpp_pkg::OSC_PIN_MASK;
      end
      rd_mux_w = 8'h00;
      unique case (reg_addr)
         gpp_pkg::ADDR_LEVEL: rd_mux_w = {2'b00, level_rd_w};
         gpp_pkg::ADDR_DIR: rd_mux_w = {2'b00, dir_rd_w};
         gpp_pkg::ADDR_LATCH: rd_mux_w = {2'b00, lat_rd_w};
         gpp_pkg::ADDR_PULLUP: rd_mux_w = {2'b00, st_r.wpu};
         gpp_pkg::ADDR_CHG_EN: rd_mux_w = {2'b00, st_r.chg_en};
         gpp_pkg::ADDR_CTRL: begin
            rd_mux_w[gpp_pkg::CTRL_GIE_BIT] = st_r.gie;
            rd_mux_w[gpp_pkg::CTRL_FLAG_BIT] = st_r.flag;
            rd_mux_w[gpp_pkg::CTRL_PUDIS_BIT] = st_r.pudis;
         end
         gpp_pkg::ADDR_ANALOG: rd_mux_w = {4'h0, st_r.analog_select_bits};
         default: rd_mux_w = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // Three-stage pin synchroniser; accept once stages two, three agree
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < 6; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.pinq[i] = st_r.s3[i];
         end
      end
      st_nxt.rdata = reg_rd ? rd_mux_w : 8'h00;
      if (reg_wr) begin
         unique case (reg_addr)
            gpp_pkg::ADDR_LEVEL: begin
               // Writes to the level register land in the latch
               st_nxt.lat = reg_wdata[5:0];
            end
            gpp_pkg::ADDR_DIR: st_nxt.dir = reg_wdata[5:0];
            gpp_pkg::ADDR_LATCH: st_nxt.lat = reg_wdata[5:0];
            gpp_pkg::ADDR_PULLUP: st_nxt.wpu = reg_wdata[5:0];
            gpp_pkg::ADDR_CHG_EN: st_nxt.chg_en = reg_wdata[5:0];
            gpp_pkg::ADDR_CTRL: begin
               st_nxt.gie = reg_wdata[gpp_pkg::CTRL_GIE_BIT];
               st_nxt.pudis = reg_wdata[gpp_pkg::CTRL_PUDIS_BIT];
               // Software may only clear the flag
               if (!reg_wdata[gpp_pkg::CTRL_FLAG_BIT]) begin
                  st_nxt.flag = 1'b0;
               end
            end
            gpp_pkg::ADDR_ANALOG: st_nxt.analog_select_bits = reg_wdata[3:0];
            default: ;
         endcase
      end
      // Capture samples the filtered level, so a change still in the
      // synchroniser at the read is not absorbed and sets the flag once it lands
      if (level_access_w) begin
         st_nxt.last = st_r.pinq;
      end
      // Set wins over a software clear in the same cycle
      if (any_mismatch_w) begin
         st_nxt.flag = 1'b1;
      end
      st_nxt.poe = ~dir_in_w;
      st_nxt.pout = st_r.lat & ~dir_in_w;
      st_nxt.pu = st_r.wpu & dir_in_w & avail_w
         & {6{~st_r.pudis}};
      if (master_clear_enable_cfg) begin
         st_nxt.pu[gpp_pkg::PIN_THREE] = 1'b1;
      end
      st_nxt.irq = st_r.flag & st_r.gie;
      if (soft_rst) begin
         // Master clear and brown-out keep the capture and the
         // synchroniser, so a standing mismatch re-sets the flag
         st_nxt = ST_RST;
         st_nxt.last = st_r.last;
         st_nxt.s1 = pin_in;
         st_nxt.s2 = st_r.s1;
         st_nxt.s3 = st_r.s2;
         st_nxt.pinq = st_r.pinq;
         st_nxt.flag = any_mismatch_w;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata = st_r.rdata;
   assign pin_out = st_r.pout;
   assign pin_oe = st_r.poe;
   assign pullup_on = st_r.pu;
   assign analog_sel = st_r.analog_select_bits;
   assign change_irq = st_r.irq;
   assign wake_req = st_r.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_drv_follows_dir;
      @(posedge core_clk) disable iff (!nrst)
      !soft_rst |=> (pin_oe == ~$past(dir_in_w));
   endproperty
   a_drv_follows_dir: assert property (p_drv_follows_dir)
      else $error("driver enable does not follow direction");

   property p_pin3_dir_one;
      @(posedge core_clk) disable iff (!nrst)
      reg_rd && reg_addr == gpp_pkg::ADDR_DIR |=> reg_rdata[3]
         && !pin_oe[3] && reg_rdata[7:6] == 2'b00;
   endproperty
   a_pin3_dir_one: assert property (p_pin3_dir_one)
      else $error("pin three direction not input");

   property p_level_wr_latch;
      @(posedge core_clk) disable iff (!nrst || soft_rst)
      reg_wr && reg_addr == gpp_pkg::ADDR_LEVEL
         |=> st_r.lat == $past(reg_wdata[5:0]);
   endproperty
   a_level_wr_latch: assert property (p_level_wr_latch)
      else $error("level write missed the latch");

   property p_access_ends_mismatch;
      @(posedge core_clk) disable iff (!nrst)
      level_access_w |=> st_r.last == $past(st_r.pinq);
   endproperty
   a_access_ends_mismatch: assert property (p_access_ends_mismatch)
      else $error("port access did not recapture");

   property p_move_keeps_capture;
      @(posedge core_clk) disable iff (!nrst)
      mem_move_access && (reg_rd || reg_wr) |=> $stable(st_r.last);
   endproperty
   a_move_keeps_capture: assert property (p_move_keeps_capture)
      else $error("move access changed capture");

   property p_mismatch_sets_flag;
      @(posedge core_clk) disable iff (!nrst || soft_rst)
      any_mismatch_w |=> st_r.flag ##1 (change_irq == $past(st_r.gie));
   endproperty
   a_mismatch_sets_flag: assert property (p_mismatch_sets_flag)
      else $error("mismatch did not set flag");

   property p_irq_gated;
      @(posedge core_clk) disable iff (!nrst)
      change_irq |-> $past(st_r.gie) && $past(st_r.flag) && wake_req;
   endproperty
   a_irq_gated: assert property (p_irq_gated)
      else $error("interrupt without enable and flag");

   property p_capture_survives;
      @(posedge core_clk) disable iff (!nrst)
      soft_rst |=> $stable(st_r.last);
   endproperty
   a_capture_survives: assert property (p_capture_survives)
      else $error("soft reset lost capture");

   property p_pullup_off_output;
      @(posedge core_clk) disable iff (!nrst)
      pin_oe != 6'h00 |-> (pullup_on & pin_oe) == 6'h00;
   endproperty
   a_pullup_off_output: assert property (p_pullup_off_output)
      else $error("pull-up active on driven pin");

   property p_pudis_all_off;
      @(posedge core_clk) disable iff (!nrst)
      st_r.pudis && !master_clear_enable_cfg |=> pullup_on == 6'h00;
   endproperty
   a_pudis_all_off: assert property (p_pudis_all_off)
      else $error("global disable left pull-up on");

   property p_master_clear_pin_pin3_zero;
      @(posedge core_clk) disable iff (!nrst)
      master_clear_enable_cfg && reg_rd && reg_addr == gpp_pkg::ADDR_LEVEL
         |=> !reg_rdata[3];
   endproperty
   a_master_clear_pin_pin3_zero: assert property (p_master_clear_pin_pin3_zero)
      else $error("pin three level visible under master clear");

   property p_osc_latch_zero;
      @(posedge core_clk) disable iff (!nrst)
      osc_claims_pins && reg_rd && reg_addr == gpp_pkg::ADDR_LATCH
         |=> reg_rdata[5:3] == 3'b000;
   endproperty
   a_osc_latch_zero: assert property (p_osc_latch_zero)
      else $error("claimed latch bits not zero");

   property p_xtal_dir_one;
      @(posedge core_clk) disable iff (!nrst)
      osc_crystal_mode && reg_rd && reg_addr == gpp_pkg::ADDR_DIR
         |=> reg_rdata[5:4] == 2'b11;
   endproperty
   a_xtal_dir_one: assert property (p_xtal_dir_one)
      else $error("crystal mode direction bits not one");

   property p_flag_held;
      @(posedge core_clk) disable iff (!nrst)
      st_r.flag && any_mismatch_w |=> st_r.flag;
   endproperty
   a_flag_held: assert property (p_flag_held)
      else $error("flag cleared while mismatch stood");

   c_flag_set: cover property (@(posedge core_clk) disable iff (!nrst)
      !st_r.flag ##1 st_r.flag);
   c_irq: cover property (@(posedge core_clk) disable iff (!nrst)
      change_irq);
   c_level_read: cover property (@(posedge core_clk) disable iff (!nrst)
      level_access_w && any_mismatch_w);
   c_soft_reset: cover property (@(posedge core_clk) disable iff (!nrst)
      soft_rst ##1 st_r.flag);
endmodule

// ==== gpp_pkg.sv ====
// Purpose: Constants for the six-bit general purpose port block.
// Assumes: Registers sit at word indices on the plain register port.
// Notes: Offsets and control bit positions are local choices.
package gpp_pkg;
   // ----------------------------------------------------------------
   // Register indices
   // ----------------------------------------------------------------
   localparam logic [2:0] ADDR_LEVEL = 3'h0;
   localparam logic [2:0] ADDR_DIR = 3'h1;
   localparam logic [2:0] ADDR_LATCH = 3'h2;
   localparam logic [2:0] ADDR_PULLUP = 3'h3;
   localparam logic [2:0] ADDR_CHG_EN = 3'h4;
   localparam logic [2:0] ADDR_CTRL = 3'h5;
   localparam logic [2:0] ADDR_ANALOG = 3'h6;

   // ----------------------------------------------------------------
   // Field positions and masks
   // ----------------------------------------------------------------
   localparam int CTRL_GIE_BIT = 0;
   localparam int CTRL_FLAG_BIT = 1;
   localparam int CTRL_PUDIS_BIT = 2;
   localparam int PIN_THREE = 3;
   localparam logic [5:0] PIN_THREE_MASK = 6'h08;
   localparam logic [5:0] OSC_PIN_MASK = 6'h30;
   localparam logic [5:0] ALL_PIN_MASK = 6'h3f;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [5:0] DIR_RST = 6'h3f;
   localparam logic [5:0] LATCH_RST = 6'h00;
   localparam logic [5:0] PULLUP_RST = 6'h3f;
   localparam logic [5:0] CHG_EN_RST = 6'h00;
   localparam logic [3:0] ANALOG_RST = 4'hf;
   localparam logic GIE_RST = 1'b0;
   localparam logic PUDIS_RST = 1'b1;
   localparam logic [5:0] LAST_RST = 6'h00;
endpackage

// ==== gpp_pins.sv ====
// Purpose: Model of the pins and board wiring around the port block.
// Assumes: Board drives a pin only where the bench says so.
// Notes: Undriven pins without pull-up float and toggle every cycle.
`timescale 1ns/100ps
module gpp_pins (
   input wire logic core_clk,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] pullup_on,
   input wire logic [5:0] ext_drv,
   input wire logic [5:0] ext_val,
   output logic [5:0] pin_lvl
);
   // ----------------------------------------------------------------
   // Wire level
   // ----------------------------------------------------------------
   logic [5:0] flt_r;
   // A toggling pattern stops the simulator settling a float to 0
   initial flt_r = 6'h2a;
   always @(posedge core_clk) flt_r <= ~flt_r;
   assign pin_lvl = (pin_oe & pin_out)
      | (~pin_oe & ext_drv & ext_val)
      | (~pin_oe & ~ext_drv & pullup_on)
      | (~pin_oe & ~ext_drv & ~pullup_on & flt_r);
endmodule

// ==== gpp_port_test.sv ====
// Purpose: Self-checking bench for the six-bit port block.
// Assumes: Straps change only while power-on reset is held.
// Notes: Reads are queued by the driver and checked by a monitor.
`timescale 1ns/100ps
module gpp_port_test;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic soft_rst = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic mem_move_access = 1'b0;
   logic [7:0] reg_rdata;
   logic mce = 1'b0;
   logic osc_cl = 1'b0;
   logic osc_xt = 1'b0;
   logic [5:0] pin_in, pin_out, pin_oe, pullup_on;
   logic [5:0] ext_drv = 6'h3f;
   logic [5:0] ext_val = 6'h08;
   logic [3:0] analog_sel;
   logic change_irq, wake_req, rd_pend = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] r;
   int n_mismatch = 0;
   int num_checks = 0;
   int seed = 97162;

   initial forever #50 core_clk = ~core_clk;

   gpp_port i_gpp_port (.core_clk(core_clk), .nrst(nrst),
      .soft_rst(soft_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .mem_move_access(mem_move_access),
      .reg_rdata(reg_rdata), .master_clear_enable_cfg(mce),
      .osc_claims_pins(osc_cl), .osc_crystal_mode(osc_xt),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_on(pullup_on), .analog_sel(analog_sel),
      .change_irq(change_irq), .wake_req(wake_req));

   gpp_pins i_gpp_pins (.core_clk(core_clk), .pin_out(pin_out),
      .pin_oe(pin_oe), .pullup_on(pullup_on), .ext_drv(ext_drv),
      .ext_val(ext_val), .pin_lvl(pin_in));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen,
            exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] e,
      input logic m = 1'b0);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      mem_move_access <= m;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
      mem_move_access <= 1'b0;
   endtask

   // Ends a little after the edge so registered outputs have landed
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #10;
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Read monitor
   // ----------------------------------------------------------------
   always @(posedge core_clk) rd_pend <= reg_rd;
   always @(negedge core_clk) begin
      if (rd_pend) begin
         if (exp_q.size() == 0)
            check(reg_rdata, 8'hxx);
         else
            check(reg_rdata, exp_q.pop_front());
      end
   end

   initial begin
      #2_000_000;
      n_mismatch++;
      end_sim();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      tick(1);
      check({2'h0, pullup_on}, 8'h00);
      rd(gpp_pkg::ADDR_DIR, 8'h3f);
      rd(gpp_pkg::ADDR_LATCH, 8'h00);
      rd(gpp_pkg::ADDR_PULLUP, 8'h3f);
      rd(gpp_pkg::ADDR_CHG_EN, 8'h00);
      rd(gpp_pkg::ADDR_CTRL, 8'h04);
      rd(gpp_pkg::ADDR_ANALOG, 8'h0f);
      wr(3'h7, 8'hff);
      rd(3'h7, 8'h00);
      wr(gpp_pkg::ADDR_ANALOG, 8'h05);
      tick(3);
      check({4'h0, analog_sel}, 8'h05);
      $display("test reset values done");
      wr(gpp_pkg::ADDR_PULLUP, 8'h15);
      wr(gpp_pkg::ADDR_CTRL, 8'h00);
      // Release pins 0, 2, 4 so only the pull-ups hold them high
      ext_drv <= 6'h2a;
      tick(8);
      check({2'h0, pullup_on}, 8'h15);
      rd(gpp_pkg::ADDR_LEVEL, 8'h1d);
      ext_drv <= 6'h3f;
      wr(gpp_pkg::ADDR_DIR, 8'h3e);
      tick(3);
      check({2'h0, pullup_on}, 8'h14);
      wr(gpp_pkg::ADDR_CTRL, 8'h04);
      tick(3);
      check({2'h0, pullup_on}, 8'h00);
      $display("test pull-ups done");
      r = 8'($random(seed));
      wr(gpp_pkg::ADDR_LEVEL, r);
      wr(gpp_pkg::ADDR_DIR, 8'h00);
      rd(gpp_pkg::ADDR_LATCH, r & 8'h37);
      rd(gpp_pkg::ADDR_DIR, 8'h08);
      tick(8);
      check({2'h0, pin_oe}, 8'h37);
      check({2'h0, pin_out}, r & 8'h37);
      rd(gpp_pkg::ADDR_LEVEL, (r & 8'h37) | 8'h08);
      $display("test direction and latch done");
      wr(gpp_pkg::ADDR_DIR, 8'h3f);
      ext_val <= 6'h00;
      tick(8);
      rd(gpp_pkg::ADDR_LEVEL, 8'h00);
      wr(gpp_pkg::ADDR_CHG_EN, 8'h07);
      wr(gpp_pkg::ADDR_CTRL, 8'h01);
      ext_val <= 6'h01;
      for (int i = 0; i < 10 && change_irq !== 1'b1; i++) tick(1);
      check({7'h0, change_irq}, 8'h01);
      check({7'h0, wake_req}, 8'h01);
      rd(gpp_pkg::ADDR_CTRL, 8'h03);
      rd(gpp_pkg::ADDR_LEVEL, 8'h01);
      wr(gpp_pkg::ADDR_CTRL, 8'h01);
      rd(gpp_pkg::ADDR_CTRL, 8'h01);
      tick(2);
      check({7'h0, change_irq}, 8'h00);
      wr(gpp_pkg::ADDR_DIR, 8'h3d);
      ext_val <= 6'h13;
      tick(8);
      rd(gpp_pkg::ADDR_CTRL, 8'h01);
      wr(gpp_pkg::ADDR_CTRL, 8'h00);
      ext_val <= 6'h15;
      tick(8);
      check({7'h0, change_irq}, 8'h00);
      rd(gpp_pkg::ADDR_CTRL, 8'h02);
      rd(gpp_pkg::ADDR_LEVEL, {7'h0, r[1]} << 1 | 8'h15, 1'b1);
      wr(gpp_pkg::ADDR_CTRL, 8'h00);
      rd(gpp_pkg::ADDR_CTRL, 8'h02);
      @(posedge core_clk);
      soft_rst <= 1'b1;
      @(posedge core_clk);
      soft_rst <= 1'b0;
      tick(3);
      rd(gpp_pkg::ADDR_CTRL, 8'h06);
      wr(gpp_pkg::ADDR_CHG_EN, 8'h07);
      wr(gpp_pkg::ADDR_CTRL, 8'h04);
      rd(gpp_pkg::ADDR_CTRL, 8'h06);
      $display("test change detect done");
      @(posedge core_clk);
      nrst <= 1'b0;
      mce <= 1'b1;
      osc_cl <= 1'b1;
      osc_xt <= 1'b1;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      tick(8);
      check({2'h0, pullup_on}, 8'h08);
      rd(gpp_pkg::ADDR_PULLUP, 8'h3f);
      // Crystal mode wins over the claim's zero on bits 5:4
      rd(gpp_pkg::ADDR_DIR, 8'h3f);
      rd(gpp_pkg::ADDR_LEVEL, 8'h05);
      wr(gpp_pkg::ADDR_LATCH, 8'h3f);
      rd(gpp_pkg::ADDR_LATCH, 8'h07);
      wr(gpp_pkg::ADDR_DIR, 8'h00);
      tick(3);
      check({2'h0, pin_oe}, 8'h07);
      $display("test straps done");
      tick(2);
      end_sim();
   end
endmodule
